// file: sstw_regs.sv
`timescale 1ns/10ps
// Strap status, self-test, serial pin voltage and watchdog register slice
// Function
// - Bit 7 of strap status sets once strap B has settled and been latched.
// - Bits 6:4 report strap B decode, 000..111 meaning mode1..mode8.
// - Bit 3 of strap status sets once strap A has settled and been latched.
// - Bits 2:0 report strap A decode, 000..011 meaning mode1..mode4.
// - Functional mode without TMDS clock and forcing bit set picks 50/50/100/25 MHz by bits 2:1.
// - With self-test on (bit 0), bits 2:1 pick pixel clock, 33 MHz or 100 MHz.
// - At power-up the voltage choice loads from its strap: low gives 3.3 V, high 1.8 V.
// - The digital reset input returns the voltage choice to 3.3 V.
// - Reading the voltage register gives 0 for 1.8 V and 1 for 3.3 V.
// - Writing 0xB5 sets the voltage choice, writing 0xB6 clears it.
// - The watchdog ends a channel transaction not done within bits 7:1 times 2 ms.
// - Watchdog control bit 0 low enables the watchdog, high disables it.
module sstw_regs
    import sstw_pkg::*;
#(
    parameter int WDOG_STEP = WDOG_STEP_CYCLES
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         digital_reset,
    input  wire logic [2:0]   mode_strap_b,
    input  wire logic [1:0]   mode_strap_a,
    input  wire logic         vsel_strap_pin,
    input  wire logic         reg_wr,
    input  wire logic [7:0]   reg_addr,
    input  wire logic [7:0]   reg_wdata,
    input  wire logic         tmds_clk_present,
    input  wire logic         osc_force,
    input  wire logic         txn_active,
    output logic      [7:0]   reg_rdata,
    output sstw_pkg::sstw_clk_sel_t clk_select,
    output logic              serial_pin_voltage_choice,
    output logic              built_in_self_test,
    output logic              txn_abort
);
    import sstw_pkg::*;

    logic       rst_m;
    logic       rst_n;
    logic [5:0] strap_m;
    logic [5:0] strap_s;
    logic [2:0] strap_b_val;
    logic [2:0] strap_a_val;
    logic       strap_b_done;
    logic       strap_a_done;
    logic       vsel_loaded;
    logic [1:0] oscillator_source_select;
    logic [6:0] wdog_timeout;
    logic       wdog_disable;
    logic [31:0] step_cnt;
    logic [6:0] step_units;
    sstw_clk_sel_t next_clk_select;
    logic [7:0] next_rdata;

    if (WDOG_STEP < 1) begin : g_bad_step
        $error("sstw_regs: WDOG_STEP must be at least 1");
    end

    // Reset release synchroniser
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_m <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_m <= 1'b1;
            rst_n <= rst_m;
        end
    end

    // Strap pin synchronisers; no reset, so the real pin level is through both
    // stages when reset lifts and the voltage strap is not taken from a reset zero
    always_ff @(posedge clk) begin
        strap_m <= {vsel_strap_pin, mode_strap_a, mode_strap_b};
        strap_s <= strap_m;
    end

    // Strap B settle and latch
    sstw_strap_latch #(.W(3), .SETTLE(STRAP_SETTLE_CYCLES)) u_strap_b (
        .clk      (clk),
        .rst_n    (rst_n),
        .pin_sync (strap_s[2:0]),
        .value    (strap_b_val),
        .done     (strap_b_done)
    );

    // Strap A settle and latch, two-bit strap widened to a 3-bit decode
    sstw_strap_latch #(.W(3), .SETTLE(STRAP_SETTLE_CYCLES)) u_strap_a (
        .clk      (clk),
        .rst_n    (rst_n),
        .pin_sync ({1'b0, strap_s[4:3]}),
        .value    (strap_a_val),
        .done     (strap_a_done)
    );

    // Voltage choice: strap at power-up, magic codes, digital reset to 3.3 V
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_pin_voltage_choice <= RST_SERIAL_PIN_VSEL[0];
            vsel_loaded               <= 1'b0;
        end else if (digital_reset) begin
            serial_pin_voltage_choice <= 1'b1;
            vsel_loaded               <= 1'b1;
        end else if (!vsel_loaded) begin
            serial_pin_voltage_choice <= ~strap_s[5];
            vsel_loaded               <= 1'b1;
        end else if (reg_wr && reg_addr == ADDR_SERIAL_PIN_VSEL) begin
            if (reg_wdata == VSEL_SET_CODE) begin
                serial_pin_voltage_choice <= 1'b1;
            end else if (reg_wdata == VSEL_CLEAR_CODE) begin
                serial_pin_voltage_choice <= 1'b0;
            end
        end
    end

    // Self-test control; reserved bits never stored
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            built_in_self_test       <= RST_SELF_TEST_CONTROL[0];
            oscillator_source_select <= RST_SELF_TEST_CONTROL[2:1];
        end else if (digital_reset) begin
            built_in_self_test       <= RST_SELF_TEST_CONTROL[0];
            oscillator_source_select <= RST_SELF_TEST_CONTROL[2:1];
        end else if (reg_wr && reg_addr == ADDR_SELF_TEST_CONTROL) begin
            built_in_self_test       <= reg_wdata[0];
            oscillator_source_select <= reg_wdata[2:1];
        end
    end

    // Watchdog control register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wdog_timeout <= RST_CC_WATCHDOG[7:1];
            wdog_disable <= RST_CC_WATCHDOG[0];
        end else if (digital_reset) begin
            wdog_timeout <= RST_CC_WATCHDOG[7:1];
            wdog_disable <= RST_CC_WATCHDOG[0];
        end else if (reg_wr && reg_addr == ADDR_CC_WATCHDOG) begin
            wdog_timeout <= reg_wdata[7:1];
            wdog_disable <= reg_wdata[0];
        end
    end

    // Watchdog: count 2 ms steps while a transaction is open
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            step_cnt   <= '0;
            step_units <= '0;
            txn_abort  <= 1'b0;
        end else if (!txn_active || wdog_disable || txn_abort) begin
            step_cnt   <= '0;
            step_units <= '0;
            txn_abort  <= 1'b0;
        end else if (step_cnt == 32'(WDOG_STEP - 1)) begin
            step_cnt   <= '0;
            step_units <= step_units + 1'b1;
            txn_abort  <= (step_units + 7'h01) >= wdog_timeout;
        end else begin
            step_cnt   <= step_cnt + 32'h1;
        end
    end

    // Clock source decode
    always_comb begin
        next_clk_select = SSTW_CLK_TMDS;
        if (built_in_self_test) begin
            unique case (oscillator_source_select)
                2'b00:   next_clk_select = SSTW_CLK_EXT_PIXEL;
                2'b01:   next_clk_select = SSTW_CLK_OSC_33;
                default: next_clk_select = SSTW_CLK_OSC_100;
            endcase
        end else if (!tmds_clk_present && osc_force) begin
            unique case (oscillator_source_select)
                2'b10:   next_clk_select = SSTW_CLK_OSC_100;
                2'b11:   next_clk_select = SSTW_CLK_OSC_25;
                default: next_clk_select = SSTW_CLK_OSC_50;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clk_select <= SSTW_CLK_TMDS;
        end else begin
            clk_select <= next_clk_select;
        end
    end

    // Read mux, registered
    always_comb begin
        unique case (reg_addr)
            ADDR_STRAP_MODE_STATUS: next_rdata = {strap_b_done, strap_b_val,
                                                  strap_a_done, strap_a_val};
            ADDR_SELF_TEST_CONTROL: next_rdata = {5'h00, oscillator_source_select,
                                                  built_in_self_test};
            ADDR_SERIAL_PIN_VSEL:   next_rdata = {7'h00, serial_pin_voltage_choice};
            ADDR_CC_WATCHDOG:       next_rdata = {wdog_timeout, wdog_disable};
            default:                next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    property p_vsel_set;
        @(posedge clk) disable iff (!rst_n)
        (reg_wr && reg_addr == ADDR_SERIAL_PIN_VSEL && reg_wdata == VSEL_SET_CODE
         && vsel_loaded && !digital_reset) |=> serial_pin_voltage_choice;
    endproperty
    a_vsel_set: assert property (p_vsel_set) else $error("vsel set code ignored");

    property p_vsel_clr;
        @(posedge clk) disable iff (!rst_n)
        (reg_wr && reg_addr == ADDR_SERIAL_PIN_VSEL && reg_wdata == VSEL_CLEAR_CODE
         && vsel_loaded && !digital_reset) |=> !serial_pin_voltage_choice;
    endproperty
    a_vsel_clr: assert property (p_vsel_clr) else $error("vsel clear code ignored");

    property p_vsel_dreset;
        @(posedge clk) disable iff (!rst_n)
        digital_reset |=> serial_pin_voltage_choice;
    endproperty
    a_vsel_dreset: assert property (p_vsel_dreset) else $error("vsel not 3.3V");

    property p_vsel_other;
        @(posedge clk) disable iff (!rst_n)
        (vsel_loaded && !digital_reset && !(reg_wr && reg_addr == ADDR_SERIAL_PIN_VSEL
         && (reg_wdata == VSEL_SET_CODE || reg_wdata == VSEL_CLEAR_CODE)))
        |=> $stable(serial_pin_voltage_choice);
    endproperty
    a_vsel_other: assert property (p_vsel_other) else $error("vsel changed");

    property p_vsel_read;
        @(posedge clk) disable iff (!rst_n)
        (reg_addr == ADDR_SERIAL_PIN_VSEL) |=> reg_rdata == {7'h00, $past(serial_pin_voltage_choice)};
    endproperty
    a_vsel_read: assert property (p_vsel_read) else $error("vsel readback wrong");

    property p_status_read;
        @(posedge clk) disable iff (!rst_n)
        (reg_addr == ADDR_STRAP_MODE_STATUS) |=> reg_rdata[STRAP_B_DONE_BIT] == $past(strap_b_done)
            && reg_rdata[STRAP_A_DONE_BIT] == $past(strap_a_done) && reg_rdata[2] == 1'b0;
    endproperty
    a_status_read: assert property (p_status_read) else $error("strap status wrong");

    property p_reserved;
        @(posedge clk) disable iff (!rst_n)
        (reg_addr == ADDR_SELF_TEST_CONTROL) |=> reg_rdata[7:3] == 5'h00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

    property p_built_in_self_test_clk;
        @(posedge clk) disable iff (!rst_n)
        (built_in_self_test && oscillator_source_select == 2'b01) |=> clk_select == SSTW_CLK_OSC_33;
    endproperty
    a_built_in_self_test_clk: assert property (p_built_in_self_test_clk) else $error("self-test clock wrong");

    property p_func_clk;
        @(posedge clk) disable iff (!rst_n)
        (!built_in_self_test && !tmds_clk_present && osc_force
         && oscillator_source_select == 2'b11) |=> clk_select == SSTW_CLK_OSC_25;
    endproperty
    a_func_clk: assert property (p_func_clk) else $error("functional clock wrong");

    property p_wdog_off;
        @(posedge clk) disable iff (!rst_n)
        wdog_disable |=> !txn_abort;
    endproperty
    a_wdog_off: assert property (p_wdog_off) else $error("abort while disabled");
endmodule // sstw_regs

// file: sstw_pkg.sv
// Package holding offsets, resets, field positions and encodings for the strap/self-test block
package sstw_pkg;
    localparam logic [7:0] ADDR_STRAP_MODE_STATUS  = 8'h13;
    localparam logic [7:0] ADDR_SELF_TEST_CONTROL  = 8'h14;
    localparam logic [7:0] ADDR_SERIAL_PIN_VSEL    = 8'h15;
    localparam logic [7:0] ADDR_CC_WATCHDOG        = 8'h16;
    localparam logic [7:0] RST_STRAP_MODE_STATUS   = 8'h88;
    localparam logic [7:0] RST_SELF_TEST_CONTROL   = 8'h00;
    localparam logic [7:0] RST_SERIAL_PIN_VSEL     = 8'h01;
    localparam logic [7:0] RST_CC_WATCHDOG         = 8'hFE;
    localparam logic [7:0] VSEL_SET_CODE           = 8'hB5;
    localparam logic [7:0] VSEL_CLEAR_CODE         = 8'hB6;
    localparam int         STRAP_B_DONE_BIT        = 7;
    localparam int         STRAP_A_DONE_BIT        = 3;
    localparam int         STRAP_SETTLE_CYCLES     = 16;
    localparam logic [6:0] WDOG_TIMEOUT_RST        = 7'h7F;
    localparam int         CLK_FREQ_HZ             = 25000000;
    localparam int         WDOG_STEP_MS            = 2;
    localparam int         WDOG_STEP_CYCLES        = CLK_FREQ_HZ / 1000 * WDOG_STEP_MS;
    // Clock choice codes presented to the clocking fabric
    typedef enum logic [2:0] {
        SSTW_CLK_OSC_50,
        SSTW_CLK_OSC_100,
        SSTW_CLK_OSC_25,
        SSTW_CLK_OSC_33,
        SSTW_CLK_EXT_PIXEL,
        SSTW_CLK_TMDS
    } sstw_clk_sel_t;
endpackage

// file: sstw_strap_latch.sv
`timescale 1ns/10ps
// Strap pin settle filter and latch
module sstw_strap_latch #(
    parameter int W       = 3,
    parameter int SETTLE  = 16
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] pin_sync,
    output logic      [W-1:0] value,
    output logic              done
);
    localparam int CW = $clog2(SETTLE + 1);
    logic [W-1:0]  last;
    logic [CW-1:0] cnt;

    if (SETTLE < 1 || W < 1) begin : g_bad_params
        $error("sstw_strap_latch: bad parameters");
    end

    // Count cycles of a steady level; latch once it has held long enough
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last  <= '0;
            cnt   <= '0;
            value <= '0;
            done  <= 1'b0;
        end else if (!done) begin
            last <= pin_sync;
            if (pin_sync != last) begin
                cnt <= '0;
            end else if (cnt == CW'(SETTLE)) begin
                value <= pin_sync;
                done  <= 1'b1;
            end else begin
                cnt <= cnt + 1'b1;
            end
        end
    end
endmodule // sstw_strap_latch

// file: sstw_regs_tb.sv
// Self-checking testbench for the strap, self-test, voltage and watchdog registers
`timescale 1ns/10ps
module sstw_regs_tb;
    import sstw_pkg::*;
    localparam int STEP = 4;
    logic          clk;
    logic          nrst;
    logic          digital_reset;
    logic [2:0]    mode_strap_b;
    logic [1:0]    mode_strap_a;
    logic          vsel_strap_pin;
    logic          reg_wr;
    logic [7:0]    reg_addr;
    logic [7:0]    reg_wdata;
    logic          tmds_clk_present;
    logic          osc_force;
    logic          txn_active;
    logic [7:0]    reg_rdata;
    sstw_clk_sel_t clk_select;
    logic          serial_pin_voltage_choice;
    logic          built_in_self_test;
    logic          txn_abort;
    logic          rd_req;
    logic          rd_seen;
    logic [7:0]    exp_q[$];
    logic [7:0]    v;
    int            n_fail;
    int            checks;
    int            n;
    sstw_clk_sel_t exp_sel [8];

    sstw_regs #(.WDOG_STEP(STEP)) i_dut (
        .clk                       (clk),
        .nrst                      (nrst),
        .digital_reset             (digital_reset),
        .mode_strap_b              (mode_strap_b),
        .mode_strap_a              (mode_strap_a),
        .vsel_strap_pin            (vsel_strap_pin),
        .reg_wr                    (reg_wr),
        .reg_addr                  (reg_addr),
        .reg_wdata                 (reg_wdata),
        .tmds_clk_present          (tmds_clk_present),
        .osc_force                 (osc_force),
        .txn_active                (txn_active),
        .reg_rdata                 (reg_rdata),
        .clk_select                (clk_select),
        .serial_pin_voltage_choice (serial_pin_voltage_choice),
        .built_in_self_test        (built_in_self_test),
        .txn_abort                 (txn_abort)
    );

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Compare one value and count it
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            n_fail++;
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Bus cycles: each starts just after a rising edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #2;
        reg_wr = 1'b1;
        rd_req = 1'b0;
        reg_addr = a;
        reg_wdata = d;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        #2;
        reg_wr = 1'b0;
        rd_req = 1'b1;
        reg_addr = a;
        exp_q.push_back(e);
    endtask

    task automatic cyc(input int k);
        repeat (k) begin
            @(posedge clk);
            #2;
            reg_wr = 1'b0;
            rd_req = 1'b0;
        end
    endtask

    // Read data is registered at the rising edge after the address is driven; take the oldest note at the next low phase
    always @(posedge clk) rd_seen <= rd_req;
    always @(negedge clk) begin
        if (rd_seen) begin
            if (exp_q.size() == 0) begin
                $display("Error at %0t: got %h expected %h", $time, reg_rdata, 8'h00);
                n_fail++;
            end else begin
                check(reg_rdata, exp_q.pop_front());
            end
        end
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        void'($urandom(51));
        exp_sel = '{SSTW_CLK_OSC_50, SSTW_CLK_EXT_PIXEL, SSTW_CLK_OSC_50, SSTW_CLK_OSC_33,
                    SSTW_CLK_OSC_100, SSTW_CLK_OSC_100, SSTW_CLK_OSC_25, SSTW_CLK_OSC_100};
        n_fail = 0;
        checks = 0;
        nrst = 1'b0;
        digital_reset = 1'b0;
        mode_strap_b = 3'($urandom);
        mode_strap_a = 2'($urandom);
        vsel_strap_pin = 1'b1;
        reg_wr = 1'b0;
        rd_req = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        tmds_clk_present = 1'b0;
        osc_force = 1'b1;
        txn_active = 1'b0;
        repeat (8) @(posedge clk);
        #2;
        nrst = 1'b1;
        cyc(40);
        // Strap status, defaults, unmapped place, high strap gives 1.8 V
        rd(ADDR_STRAP_MODE_STATUS, {1'b1, mode_strap_b, 1'b1, 1'b0, mode_strap_a});
        rd(ADDR_SERIAL_PIN_VSEL, 8'h00);
        rd(ADDR_SELF_TEST_CONTROL, RST_SELF_TEST_CONTROL);
        rd(ADDR_CC_WATCHDOG, RST_CC_WATCHDOG);
        rd(8'h20, 8'h00);
        cyc(1);
        check({7'h00, serial_pin_voltage_choice}, 8'h00);
        // Writes that must change nothing, then the two codes
        v = 8'($urandom);
        if (v == VSEL_SET_CODE || v == VSEL_CLEAR_CODE) v = 8'h00;
        wr(ADDR_STRAP_MODE_STATUS, 8'h00);
        wr(ADDR_SERIAL_PIN_VSEL, v);
        rd(ADDR_STRAP_MODE_STATUS, {1'b1, mode_strap_b, 1'b1, 1'b0, mode_strap_a});
        rd(ADDR_SERIAL_PIN_VSEL, 8'h00);
        wr(ADDR_SERIAL_PIN_VSEL, VSEL_SET_CODE);
        rd(ADDR_SERIAL_PIN_VSEL, 8'h01);
        cyc(1);
        check({7'h00, serial_pin_voltage_choice}, 8'h01);
        wr(ADDR_SERIAL_PIN_VSEL, VSEL_CLEAR_CODE);
        rd(ADDR_SERIAL_PIN_VSEL, 8'h00);
        // Reserved self-test bits
        wr(ADDR_SELF_TEST_CONTROL, 8'hFF);
        rd(ADDR_SELF_TEST_CONTROL, 8'h07);
        // Every source code with self-test off and on, no line clock, forcing bit set
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_SELF_TEST_CONTROL, 8'(i));
            rd(ADDR_SELF_TEST_CONTROL, 8'(i));
            cyc(3);
            check({5'h00, clk_select}, {5'h00, exp_sel[i]});
            check({7'h00, built_in_self_test}, {7'h00, i[0]});
        end
        // Line clock present in functional mode
        wr(ADDR_SELF_TEST_CONTROL, 8'h04);
        cyc(1);
        tmds_clk_present = 1'b1;
        cyc(3);
        check({5'h00, clk_select}, {5'h00, SSTW_CLK_TMDS});
        tmds_clk_present = 1'b0;
        // Digital reset returns 3.3 V from the cleared state
        digital_reset = 1'b1;
        cyc(1);
        digital_reset = 1'b0;
        cyc(2);
        check({7'h00, serial_pin_voltage_choice}, 8'h01);
        rd(ADDR_SERIAL_PIN_VSEL, 8'h01);
        // Watchdog: timeout 3 steps, enabled
        wr(ADDR_CC_WATCHDOG, 8'h06);
        cyc(1);
        txn_active = 1'b1;
        n = 0;
        while (txn_abort !== 1'b1 && n < 100) begin
            cyc(1);
            n++;
        end
        txn_active = 1'b0;
        check(8'(n >= 3 * STEP && n <= 3 * STEP + 3), 8'h01);
        // Watchdog disabled: no abort for a long transaction
        wr(ADDR_CC_WATCHDOG, 8'h07);
        rd(ADDR_CC_WATCHDOG, 8'h07);
        cyc(1);
        txn_active = 1'b1;
        n = 0;
        repeat (40) begin
            cyc(1);
            if (txn_abort !== 1'b0) n++;
        end
        txn_active = 1'b0;
        check(8'(n), 8'h00);
        // Second power-up with the voltage strap low selects 3.3 V
        reg_addr = 8'h00;
        vsel_strap_pin = 1'b0;
        nrst = 1'b0;
        cyc(4);
        nrst = 1'b1;
        cyc(4);
        check({7'h00, serial_pin_voltage_choice}, 8'h01);
        rd(ADDR_SERIAL_PIN_VSEL, 8'h01);
        rd(ADDR_CC_WATCHDOG, RST_CC_WATCHDOG);
        cyc(3);
        check(8'(exp_q.size()), 8'h00);
        report_and_stop();
    end
endmodule // sstw_regs_tb
